// file: rtl/cbbc_regs.sv
// Bridge control and subsystem vendor registers for two bridge functions.
`timescale 1ns/1ps
`include "cbbc_map.svh"
module cbbc_regs (
   // Clock and resets; i_nrst is the global reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_pci_bus_reset,
   input wire logic i_pme_enable,
   // Configuration access
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic i_cfg_func,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [15:0] i_cfg_wdata,
   output logic [15:0] o_cfg_rdata,
   output logic o_cfg_hit,
   // System control lock
   input wire logic i_subsystem_write_lock,
   // Serial configuration memory
   input wire logic i_eeprom_present,
   input wire logic i_eeprom_valid,
   input wire logic [15:0] i_eeprom_vendor,
   output logic o_eeprom_load_req,
   // Card side events, per socket
   input wire logic [1:0] i_card_system_error,
   input wire logic [1:0] i_card_parity_error_det,
   input wire logic [1:0] i_card_master_abort,
   input wire logic [1:0] i_card_irq,
   input wire logic [15:0] i_io_addr,
   input wire logic i_serr_enable,
   // Decisions and outputs
   output logic [1:0] o_card_reset_out,
   output logic [1:0] o_write_post_enable,
   output logic [1:0] o_mem_window0_prefetchable,
   output logic [1:0] o_mem_window1_prefetchable,
   output logic [1:0] o_irq_to_pci,
   output logic [1:0] o_irq_to_legacy,
   output logic [1:0] o_io_forward_ok,
   output logic o_vga_forward_enable,
   output logic o_target_abort,
   output logic o_serr,
   output logic [1:0] o_card_parity_error
);
   typedef struct packed {
      logic master_abort_report_mode;
      logic vga_forward_enable;
      logic [15:0] subsys_vendor;
      cbbc_pkg::cbbc_load_t load;
      logic [15:0] rdata;
      logic hit;
      logic [1:0] card_reset_out;
      logic target_abort;
      logic serr;
      logic [1:0] perr;
      logic [1:0] irq_pci;
      logic [1:0] irq_legacy;
      logic [1:0] io_ok;
   } cbbc_state_t;

   cbbc_state_t r;
   cbbc_state_t next_r;
   cbbc_pkg::cbbc_sock_t sock [2];
   logic [1:0] sock_card_rst;
   logic [1:0] sock_wr;

   function automatic logic [15:0] cbbc_bctl_read(input cbbc_pkg::cbbc_sock_t s,
                                                input logic card_rst, input logic mabt,
                                                input logic vga);
      logic [15:0] v;
      v = 16'h0000;
      v[`CBBC_BIT_POST] = s.write_post_enable;
      v[`CBBC_BIT_PF1] = s.mem_window1_prefetchable;
      v[`CBBC_BIT_PF0] = s.mem_window0_prefetchable;
      v[`CBBC_BIT_IRQ_ROUTE] = s.functional_irq_route_select;
      v[`CBBC_BIT_CARD_RST] = card_rst;
      v[`CBBC_BIT_MABT] = mabt;
      v[`CBBC_BIT_VGA] = vga;
      v[`CBBC_BIT_ISA] = s.isa_range_filter_enable;
      v[`CBBC_BIT_SERR_EN] = s.card_syserr_forward_enable;
      v[`CBBC_BIT_PERR_EN] = s.card_parity_response_enable;
      return v;
   endfunction

   // Last 768 bytes of a 1K block have address bits 9:8 nonzero
   function automatic logic cbbc_isa_blocked(input logic [15:0] a);
      return (a[9:0] & `CBBC_ISA_KEEP_MASK) != 10'h000;
   endfunction

   // Socket bits: one copy per function
   for (genvar g = 0; g < 2; g++) begin : g_sock
      assign sock_wr[g] = i_cfg_wr && (i_cfg_func == 1'(g)) &&
                          (i_cfg_addr == `CBBC_OFF_BRIDGE_CTRL);
      cbbc_socket u_sock (
         .i_sys_clk(i_sys_clk),
         .i_nrst(i_nrst),
         .i_pci_bus_reset(i_pci_bus_reset),
         .i_pme_enable(i_pme_enable),
         .i_wr(sock_wr[g]),
         .i_wdata(i_cfg_wdata),
         .o_bits(sock[g]),
         .o_card_reset_bit(sock_card_rst[g])
      );
   end

   always_comb begin
      next_r = r;
      next_r.hit = 1'b0;
      if (i_pci_bus_reset) begin
         // Master abort mode survives bus reset; VGA enable does not
         next_r.vga_forward_enable = 1'b0;
      end else if (i_cfg_wr && i_cfg_addr == `CBBC_OFF_BRIDGE_CTRL && !i_cfg_func) begin
         // Shared bits only from function 0
         next_r.master_abort_report_mode = i_cfg_wdata[`CBBC_BIT_MABT];
         next_r.vga_forward_enable = i_cfg_wdata[`CBBC_BIT_VGA];
      end
      if (i_cfg_wr && i_cfg_addr == `CBBC_OFF_SUBSYS_VENDOR && !i_subsystem_write_lock) begin
         next_r.subsys_vendor = i_cfg_wdata;
      end
      case (r.load)
         cbbc_pkg::CBBC_LOAD_IDLE: begin
            if (i_eeprom_present) begin
               next_r.load = cbbc_pkg::CBBC_LOAD_WAIT;
            end else begin
               next_r.load = cbbc_pkg::CBBC_LOAD_DONE;
            end
         end
         cbbc_pkg::CBBC_LOAD_WAIT: begin
            if (i_eeprom_valid) begin
               next_r.subsys_vendor = i_eeprom_vendor;
               next_r.load = cbbc_pkg::CBBC_LOAD_DONE;
            end
         end
         cbbc_pkg::CBBC_LOAD_DONE: begin
            next_r.load = cbbc_pkg::CBBC_LOAD_DONE;
         end
         default: begin
            next_r.load = cbbc_pkg::CBBC_LOAD_IDLE;
         end
      endcase
      next_r.rdata = 16'h0000;
      if (i_cfg_rd) begin
         if (i_cfg_addr == `CBBC_OFF_BRIDGE_CTRL) begin
            next_r.rdata = cbbc_bctl_read(sock[i_cfg_func], sock_card_rst[i_cfg_func],
                                          r.master_abort_report_mode, r.vga_forward_enable);
            next_r.hit = 1'b1;
         end else if (i_cfg_addr == `CBBC_OFF_SUBSYS_VENDOR) begin
            next_r.rdata = r.subsys_vendor;
            next_r.hit = 1'b1;
         end
      end
      next_r.target_abort = 1'b0;
      next_r.serr = 1'b0;
      for (int s = 0; s < 2; s++) begin
         next_r.card_reset_out[s] = sock_card_rst[s] || i_pci_bus_reset;
         if (i_card_master_abort[s] && r.master_abort_report_mode) begin
            next_r.target_abort = 1'b1;
            if (i_serr_enable) begin
               next_r.serr = 1'b1;
            end
         end
         if (i_card_system_error[s] && sock[s].card_syserr_forward_enable && i_serr_enable) begin
            next_r.serr = 1'b1;
         end
         next_r.perr[s] = i_card_parity_error_det[s] &&
                          sock[s].card_parity_response_enable;
         next_r.irq_pci[s] = i_card_irq[s] && !sock[s].functional_irq_route_select;
         next_r.irq_legacy[s] = i_card_irq[s] && sock[s].functional_irq_route_select;
         next_r.io_ok[s] = !(sock[s].isa_range_filter_enable &&
                             cbbc_isa_blocked(i_io_addr));
      end
   end

   // Global reset only; the bus reset is handled synchronously above
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '{master_abort_report_mode: 1'b0, vga_forward_enable: 1'b0,
                subsys_vendor: `CBBC_SUBSYS_VENDOR_RESET,
                load: cbbc_pkg::CBBC_LOAD_IDLE, rdata: 16'h0000, hit: 1'b0,
                card_reset_out: 2'b11, target_abort: 1'b0, serr: 1'b0,
                perr: 2'b00, irq_pci: 2'b00, irq_legacy: 2'b00, io_ok: 2'b11};
      end else begin
         r <= next_r;
      end
   end

   assign o_cfg_rdata = r.rdata;
   assign o_cfg_hit = r.hit;
   assign o_eeprom_load_req = (r.load == cbbc_pkg::CBBC_LOAD_WAIT);
   assign o_card_reset_out = r.card_reset_out;
   for (genvar g = 0; g < 2; g++) begin : g_out
      assign o_write_post_enable[g] = sock[g].write_post_enable;
      assign o_mem_window0_prefetchable[g] = sock[g].mem_window0_prefetchable;
      assign o_mem_window1_prefetchable[g] = sock[g].mem_window1_prefetchable;
   end
   assign o_irq_to_pci = r.irq_pci;
   assign o_irq_to_legacy = r.irq_legacy;
   assign o_io_forward_ok = r.io_ok;
   assign o_vga_forward_enable = r.vga_forward_enable;
   assign o_target_abort = r.target_abort;
   assign o_serr = r.serr;
   assign o_card_parity_error = r.perr;
endmodule

// file: rtl/cbbc_map.svh
// Constants for the bridge control and subsystem vendor registers.
`ifndef CBBC_MAP_SVH
`define CBBC_MAP_SVH
`define CBBC_OFF_BRIDGE_CTRL 8'h3E
`define CBBC_OFF_SUBSYS_VENDOR 8'h40
`define CBBC_BRIDGE_CTRL_RESET 16'h0340
// Arbitrary identifier reset value of our own choosing
`define CBBC_SUBSYS_VENDOR_RESET 16'h1D2B
`define CBBC_BIT_POST 10
`define CBBC_BIT_PF1 9
`define CBBC_BIT_PF0 8
`define CBBC_BIT_IRQ_ROUTE 7
`define CBBC_BIT_CARD_RST 6
`define CBBC_BIT_MABT 5
`define CBBC_BIT_VGA 3
`define CBBC_BIT_ISA 2
`define CBBC_BIT_SERR_EN 1
`define CBBC_BIT_PERR_EN 0
`define CBBC_ISA_TOP 16'hFFFF
`define CBBC_ISA_KEEP_MASK 10'h300
`endif

// file: rtl/cbbc_pkg.sv
// Types shared by the bridge control register block.
package cbbc_pkg;
   typedef struct packed {
      logic write_post_enable;
      logic mem_window1_prefetchable;
      logic mem_window0_prefetchable;
      logic functional_irq_route_select;
      logic isa_range_filter_enable;
      logic card_syserr_forward_enable;
      logic card_parity_response_enable;
   } cbbc_sock_t;

   typedef enum logic [2:0] {
      CBBC_LOAD_IDLE = 3'b001,
      CBBC_LOAD_WAIT = 3'b010,
      CBBC_LOAD_DONE = 3'b100
   } cbbc_load_t;
endpackage

// file: rtl/cbbc_socket.sv
// One socket's copy of the socket-dependent bridge control bits.
`timescale 1ns/1ps
`include "cbbc_map.svh"
module cbbc_socket (
   // Clock and resets
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_pci_bus_reset,
   input wire logic i_pme_enable,
   // Register write
   input wire logic i_wr,
   input wire logic [15:0] i_wdata,
   // State
   output cbbc_pkg::cbbc_sock_t o_bits,
   output logic o_card_reset_bit
);
   typedef struct packed {
      cbbc_pkg::cbbc_sock_t bits;
      logic card_reset;
   } cbbc_sock_state_t;

   cbbc_sock_state_t r;
   cbbc_sock_state_t next_r;

   always_comb begin
      next_r = r;
      if (i_pci_bus_reset) begin
         // Card reset bit is PME context and survives bus reset then
         if (!i_pme_enable) begin
            next_r.card_reset = 1'b1;
         end
         next_r.bits.write_post_enable = 1'b0;
         next_r.bits.mem_window1_prefetchable = 1'b1;
         next_r.bits.mem_window0_prefetchable = 1'b1;
         next_r.bits.functional_irq_route_select = 1'b0;
         next_r.bits.isa_range_filter_enable = 1'b0;
         next_r.bits.card_syserr_forward_enable = 1'b0;
         next_r.bits.card_parity_response_enable = 1'b0;
      end else if (i_wr) begin
         next_r.bits.write_post_enable = i_wdata[`CBBC_BIT_POST];
         next_r.bits.mem_window1_prefetchable = i_wdata[`CBBC_BIT_PF1];
         next_r.bits.mem_window0_prefetchable = i_wdata[`CBBC_BIT_PF0];
         next_r.bits.functional_irq_route_select = i_wdata[`CBBC_BIT_IRQ_ROUTE];
         next_r.card_reset = i_wdata[`CBBC_BIT_CARD_RST];
         next_r.bits.isa_range_filter_enable = i_wdata[`CBBC_BIT_ISA];
         next_r.bits.card_syserr_forward_enable = i_wdata[`CBBC_BIT_SERR_EN];
         next_r.bits.card_parity_response_enable = i_wdata[`CBBC_BIT_PERR_EN];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign o_bits = r.bits;
   assign o_card_reset_bit = r.card_reset;
endmodule

// file: verif/cbbc_regs_assertions.sv
// Port-level checker for the bridge control register block.
`timescale 1ns/1ps
module cbbc_regs_checker (
   // Clock and resets
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_pci_bus_reset,
   // Configuration access
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [15:0] o_cfg_rdata,
   input wire logic o_cfg_hit,
   // Card events and decisions
   input wire logic [1:0] i_card_system_error,
   input wire logic [1:0] i_card_parity_error_det,
   input wire logic [1:0] i_card_master_abort,
   input wire logic [1:0] i_card_irq,
   input wire logic [15:0] i_io_addr,
   input wire logic i_serr_enable,
   input wire logic [1:0] o_card_reset_out,
   input wire logic [1:0] o_irq_to_pci,
   input wire logic [1:0] o_irq_to_legacy,
   input wire logic [1:0] o_io_forward_ok,
   input wire logic o_target_abort,
   input wire logic o_serr,
   input wire logic [1:0] o_card_parity_error
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   sequence rd_bc_s;
      i_cfg_rd && i_cfg_addr == 8'h3E;
   endsequence
   sequence rd_miss_s;
      i_cfg_rd && i_cfg_addr != 8'h3E && i_cfg_addr != 8'h40;
   endsequence
   chk_rsvd_read_zero: assert property (
      rd_bc_s |=> o_cfg_hit && o_cfg_rdata[15:11] == 5'h00 && !o_cfg_rdata[4])
      else $error("reserved bits read nonzero");
   chk_unmapped_read: assert property (
      rd_miss_s |=> !o_cfg_hit && o_cfg_rdata == 16'h0000)
      else $error("unmapped read answered");
   chk_bus_reset_card: assert property (
      i_pci_bus_reset |=> o_card_reset_out == 2'b11)
      else $error("card reset not driven in bus reset");
   chk_irq_route_one: assert property (
      1'b1 |=> (o_irq_to_pci | o_irq_to_legacy) == $past(i_card_irq) &&
      (o_irq_to_pci & o_irq_to_legacy) == 2'b00)
      else $error("card interrupt misrouted");
   chk_parity_cause: assert property (
      1'b1 |=> (o_card_parity_error & ~$past(i_card_parity_error_det)) == 2'b00)
      else $error("parity error without cause");
   chk_serr_cause: assert property (
      (!i_serr_enable || (i_card_system_error == 2'b00 && i_card_master_abort == 2'b00))
      |=> !o_serr)
      else $error("serr without cause");
   chk_abort_cause: assert property (
      i_card_master_abort == 2'b00 |=> !o_target_abort)
      else $error("target abort without cause");
   chk_io_low_pass: assert property (
      i_io_addr[9:8] == 2'b00 |=> o_io_forward_ok == 2'b11)
      else $error("low quarter of 1K blocked");
endmodule
bind cbbc_regs cbbc_regs_checker u_chk (.*);

// file: verif/cbbc_eeprom_model.sv
// Serial configuration memory model that answers the vendor load.
`timescale 1ns/1ps
module cbbc_eeprom_model #(
   parameter logic [15:0] VENDOR = 16'h5A3C, // Arbitrary value
   parameter int DLY = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_fitted,
   input wire logic i_load_req,
   output logic o_present,
   output logic o_valid,
   output logic [15:0] o_vendor
);
   int cnt = 0;
   assign o_present = i_fitted;
   initial o_valid = 1'b0;
   initial o_vendor = 16'hA5C3;
   always @(posedge i_sys_clk) begin
      o_valid <= 1'b0;
      // Data toggles outside valid so stale values never look good
      o_vendor <= ~o_vendor;
      cnt <= i_load_req ? cnt + 1 : 0;
      if (i_load_req && cnt == DLY) begin
         o_valid <= 1'b1;
         o_vendor <= VENDOR;
      end
   end
endmodule

// file: verif/cbbc_regs_tb.sv
// Self-checking bench for the bridge control register block.
`timescale 1ns/1ps
`include "cbbc_map.svh"
module cbbc_regs_tb;
   // Arbitrary vendor value held by the configuration memory
   localparam logic [15:0] EE = 16'h5A3C;
   logic i_sys_clk = 1'b0, i_nrst, bus_rst = 0, pme = 0, wr = 0, rd = 0, func = 0, lock = 1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, io = 16'h0000, rdata, ee_vend, vend;
   logic [1:0] cse = 2'h0, perr = 2'h0, mab = 2'h0, irq = 2'h0;
   logic serr_en = 0, fitted = 1, hit, ee_pres, ee_val, ee_req, vga_o, ta_o, serr_o;
   logic [1:0] card_rst_o, post_o, pf0_o, pf1_o, pci_o, leg_o, iook_o, perr_o;
   logic [15:0] sock [2];
   logic [15:0] shared;
   int n_fail = 0, compares = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   cbbc_regs dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_pci_bus_reset(bus_rst),
      .i_pme_enable(pme), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_func(func), .i_cfg_addr(addr),
      .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_hit(hit), .i_subsystem_write_lock(lock),
      .i_eeprom_present(ee_pres), .i_eeprom_valid(ee_val), .i_eeprom_vendor(ee_vend),
      .o_eeprom_load_req(ee_req), .i_card_system_error(cse), .i_card_parity_error_det(perr),
      .i_card_master_abort(mab), .i_card_irq(irq), .i_io_addr(io), .i_serr_enable(serr_en),
      .o_card_reset_out(card_rst_o), .o_write_post_enable(post_o),
      .o_mem_window0_prefetchable(pf0_o), .o_mem_window1_prefetchable(pf1_o),
      .o_irq_to_pci(pci_o), .o_irq_to_legacy(leg_o),
      .o_io_forward_ok(iook_o), .o_vga_forward_enable(vga_o), .o_target_abort(ta_o),
      .o_serr(serr_o), .o_card_parity_error(perr_o));
   cbbc_eeprom_model #(.VENDOR(EE)) mem (.i_sys_clk(i_sys_clk), .i_fitted(fitted),
      .i_load_req(ee_req), .o_present(ee_pres), .o_valid(ee_val), .o_vendor(ee_vend));
   function automatic logic [15:0] z(logic [1:0] v);
      return {14'h0, v};
   endfunction
   task automatic wrap_up();
      $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg(logic w, logic f, logic [7:0] a, logic [15:0] d);
      wr = w;
      rd = !w;
      func = f;
      addr = a;
      wdata = d;
      @(negedge i_sys_clk);
   endtask
   task automatic idle();
      wr = 0;
      rd = 0;
      @(negedge i_sys_clk);
   endtask
   task automatic rdchk(logic f, logic [7:0] a, logic [15:0] e, logic h);
      cfg(0, f, a, 16'h0000);
      chk("rdata", e, rdata);
      chk("hit", z(h), z(hit));
   endtask
   task automatic wbc(logic f, logic [15:0] d);
      cfg(1, f, 8'h3E, d);
      sock[f] = d & 16'h07C7;
      if (!f) shared = d & 16'h0028;
   endtask
   task automatic global_reset();
      i_nrst = 0;
      sock[0] = 16'h0340;
      sock[1] = 16'h0340;
      shared = 16'h0000;
      vend = fitted ? EE : `CBBC_SUBSYS_VENDOR_RESET;
      repeat (5) @(negedge i_sys_clk);
      chk("rst_card", 16'h0003, z(card_rst_o));
      i_nrst = 1;
      repeat (2) @(negedge i_sys_clk);
      for (int i = 0; i < 40 && ee_req; i++) @(negedge i_sys_clk);
      chk("load_req", 16'h0000, z(ee_req));
   endtask
   task automatic ev_round();
      logic [1:0] rt, isa;
      logic mao;
      {cse, perr, mab, irq} = 8'($urandom);
      serr_en = 1'($urandom);
      io = 16'($urandom);
      idle();
      rt = {sock[1][7], sock[0][7]};
      isa = {sock[1][2], sock[0][2]};
      mao = shared[5] & |mab;
      chk("irq_pci", z(irq & ~rt), z(pci_o));
      chk("irq_legacy", z(irq & rt), z(leg_o));
      chk("parity", z(perr & {sock[1][0], sock[0][0]}), z(perr_o));
      chk("abort", z(mao), z(ta_o));
      chk("serr", z(serr_en & (mao | |(cse & {sock[1][1], sock[0][1]}))), z(serr_o));
      chk("io_ok", z(~(isa & {2{io[9:8] != 2'b00}})), z(iook_o));
      chk("post", z({sock[1][10], sock[0][10]}), z(post_o));
      chk("pf1", z({sock[1][9], sock[0][9]}), z(pf1_o));
      chk("pf0", z({sock[1][8], sock[0][8]}), z(pf0_o));
      chk("vga", z(shared[3]), z(vga_o));
      chk("card_rst", z({sock[1][6], sock[0][6]}), z(card_rst_o));
   endtask
   initial begin
      repeat (5000) @(posedge i_sys_clk);
      n_fail++;
      wrap_up();
   end
   initial begin
      void'($urandom(46));
      global_reset();
      rdchk(0, 8'h3E, 16'h0340, 1);
      rdchk(1, 8'h3E, 16'h0340, 1);
      rdchk(1, 8'h40, EE, 1);
      rdchk(0, 8'h42, 16'h0000, 0);
      ev_round();
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         wbc(1'(i), i < 2 ? 16'hFFFF : (i < 4 ? 16'h0000 : 16'($urandom)));
         ev_round();
         rdchk(0, 8'h3E, sock[0] | shared, 1);
         rdchk(1, 8'h3E, sock[1] | shared, 1);
      end
      $display("test random done");
      cfg(1, 0, 8'h40, 16'h1234);
      rdchk(0, 8'h40, vend, 1);
      lock = 0;
      cfg(1, 1, 8'h40, 16'hC3A5);
      rdchk(0, 8'h40, 16'hC3A5, 1);
      lock = 1;
      vend = 16'hC3A5;
      $display("test lock done");
      for (int p = 0; p < 2; p++) begin
         wbc(0, 16'h0028);
         wbc(1, 16'h0000);
         idle();
         pme = 1'(p);
         bus_rst = 1;
         repeat (2) @(negedge i_sys_clk);
         chk("bus_rst_card", 16'h0003, z(card_rst_o));
         bus_rst = 0;
         for (int f = 0; f < 2; f++) sock[f] = 16'h0300 | (p ? sock[f] & 16'h0040 : 16'h0040);
         shared = shared & 16'h0020;
         idle();
         ev_round();
         rdchk(0, 8'h3E, sock[0] | shared, 1);
         rdchk(1, 8'h40, vend, 1);
      end
      $display("test bus reset done");
      fitted = 0;
      global_reset();
      rdchk(0, 8'h40, `CBBC_SUBSYS_VENDOR_RESET, 1);
      rdchk(1, 8'h3E, 16'h0340, 1);
      $display("test global reset done");
      wrap_up();
   end
endmodule
